// >>> pkg/bcdalu_regs.vh
// Constants for the decimal-add and decrement datapath slice.
// Assumes inclusion by the design files of this block only.
`ifndef BCDALU_REGS_VH
`define BCDALU_REGS_VH
`define BCDALU_DATA_W 8
`define BCDALU_ADDR_W 8
`define BCDALU_OP_DAC 2'h1
`define BCDALU_OP_DEC 2'h2
`define BCDALU_OFF_CTRL 8'h00
`define BCDALU_OFF_SRC 8'h01
`define BCDALU_OFF_STATUS 8'h02
`define BCDALU_OFF_RESULT 8'h03
`define BCDALU_OFF_SEL 8'h04
`define BCDALU_OFF_FILE 8'h10
`define BCDALU_CTRL_GO_DAC 0
`define BCDALU_CTRL_GO_DEC 1
`define BCDALU_ST_C 0
`define BCDALU_ST_N 1
`define BCDALU_ST_Z 2
`define BCDALU_ST_V 3
`define BCDALU_ST_RESET 4'h0
`define BCDALU_FILE_DEPTH 16
`define BCDALU_FILE_AW 4
`endif

// >>> src/bcdalu_core.v
// Decimal add with carry and register decrement datapath with status flags.
// Assumes a synchronous register port master and a single 25 MHz clock.
// Function
// - Binary add with carry, decimal correct, store.
// - Carry set when decimal sum exceeds 99.
// - Operands are packed BCD; others undefined.
// - Zero source gives increment on carry.
// - Existing carry chains multi-byte decimal adds.
// - Decrement any register by one, store back.
// - Decrement carry clear only on 00 wrap.
// - Decrement overflow only on 80 to 7F.
`timescale 1ns/100ps
`include "bcdalu_regs.vh"
module bcdalu_core #(
   parameter DW = `BCDALU_DATA_W,
   parameter AW = `BCDALU_ADDR_W
) (
   input wire ref_clk,
   input wire rst_b,
   input wire [AW-1:0] regAddr,
   input wire [DW-1:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   output reg [DW-1:0] regRdData
);
   localparam FAW = `BCDALU_FILE_AW;
   localparam S_IDLE = 2'h0;
   localparam S_FETCH = 2'h1;
   localparam S_EXEC = 2'h2;

   reg [1:0] state_reg;
   reg [1:0] op_reg;
   reg [DW-1:0] src_reg;
   reg [FAW-1:0] selected_register_reg;
   reg [3:0] status_reg;
   reg [DW-1:0] result_reg;
   reg rdPend_reg;
   reg [AW-1:0] rdAddr_reg;
   reg [1:0] state_next;

   wire [DW-1:0] fileRd;
   wire fileHit = (regAddr >= `BCDALU_OFF_FILE)
      && (regAddr < (`BCDALU_OFF_FILE + `BCDALU_FILE_DEPTH));
   wire [FAW-1:0] fileIdx = regAddr[FAW-1:0];
   wire busFileWr = regWrStb && fileHit && (state_reg == S_IDLE);
   wire goDac = regWrStb && (regAddr == `BCDALU_OFF_CTRL)
      && regWrData[`BCDALU_CTRL_GO_DAC];
   wire goDec = regWrStb && (regAddr == `BCDALU_OFF_CTRL)
      && regWrData[`BCDALU_CTRL_GO_DEC] && !regWrData[`BCDALU_CTRL_GO_DAC];

   // Binary sum first, then per-digit correction by six.
   // Non-decimal nibbles simply flow through the same adders.
   wire carryIn = status_reg[`BCDALU_ST_C];
   wire [8:0] binSum = {1'b0, src_reg} + {1'b0, fileRd} + {8'h00, carryIn};
   wire [4:0] loSum = {1'b0, src_reg[3:0]} + {1'b0, fileRd[3:0]} + {4'h0, carryIn};
   wire loAdj = (loSum > 5'h09);
   wire [8:0] sumLo = binSum + (loAdj ? 9'h006 : 9'h000);
   wire hiAdj = (sumLo[8:4] > 5'h09);
   wire [9:0] decSum = {1'b0, sumLo} + (hiAdj ? 10'h060 : 10'h000);
   // A zero source adds only the carry, so this is an increment on carry.
   wire [DW-1:0] dacRes = decSum[7:0];
   wire dacCarry = hiAdj;
   wire [DW-1:0] decRes = fileRd - 8'h01;
   wire decCarry = (fileRd != 8'h00);
   wire decOvf = (fileRd == 8'h80);
   wire [DW-1:0] opRes = (op_reg == `BCDALU_OP_DAC) ? dacRes : decRes;
   wire execWr = (state_reg == S_EXEC);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (goDac || goDec) begin
               state_next = S_FETCH;
            end
         end
         S_FETCH: begin
            state_next = S_EXEC;
         end
         S_EXEC: begin
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // The file read port is shared; while an operation runs it looks at the operand.
   wire [FAW-1:0] fileRdAddr = (state_reg == S_IDLE) ? fileIdx : selected_register_reg;

   bcdalu_regfile #(
      .DW(DW),
      .AW(FAW),
      .DEPTH(`BCDALU_FILE_DEPTH)
   ) u_file (
      .ref_clk(ref_clk),
      .wrEn(busFileWr || execWr),
      .wrAddr(execWr ? selected_register_reg : fileIdx),
      .wrData(execWr ? opRes : regWrData),
      .rdAddr(fileRdAddr),
      .rdData(fileRd)
   );

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= S_IDLE;
         op_reg <= 2'h0;
         src_reg <= 8'h00;
         selected_register_reg <= 4'h0;
         status_reg <= `BCDALU_ST_RESET;
         result_reg <= 8'h00;
         rdPend_reg <= 1'b0;
         rdAddr_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         rdPend_reg <= regRdStb;
         rdAddr_reg <= regAddr;
         if (state_reg == S_IDLE && (goDac || goDec)) begin
            op_reg <= goDac ? `BCDALU_OP_DAC : `BCDALU_OP_DEC;
         end
         if (regWrStb && regAddr == `BCDALU_OFF_SRC && state_reg == S_IDLE) begin
            src_reg <= regWrData;
         end
         if (regWrStb && regAddr == `BCDALU_OFF_SEL && state_reg == S_IDLE) begin
            selected_register_reg <= regWrData[FAW-1:0];
         end
         if (execWr) begin
            result_reg <= opRes;
            status_reg[`BCDALU_ST_N] <= opRes[7];
            status_reg[`BCDALU_ST_Z] <= (opRes == 8'h00);
            if (op_reg == `BCDALU_OP_DAC) begin
               status_reg[`BCDALU_ST_C] <= dacCarry;
               // Overflow has no meaning for a decimal add; it is simply cleared.
               status_reg[`BCDALU_ST_V] <= 1'b0;
            end else begin
               status_reg[`BCDALU_ST_C] <= decCarry;
               status_reg[`BCDALU_ST_V] <= decOvf;
            end
         end else if (regWrStb && regAddr == `BCDALU_OFF_STATUS && state_reg == S_IDLE) begin
            // Software clears carry here before the first byte of a chain.
            status_reg <= regWrData[3:0];
         end
      end
   end

   // Read data stand only in the cycle after the strobe; unmapped reads give zero.
   always @* begin
      regRdData = 8'h00;
      if (rdPend_reg) begin
         case (rdAddr_reg)
            `BCDALU_OFF_CTRL: regRdData = {6'h00, op_reg & {2{state_reg != S_IDLE}}};
            `BCDALU_OFF_SRC: regRdData = src_reg;
            `BCDALU_OFF_STATUS: regRdData = {4'h0, status_reg};
            `BCDALU_OFF_RESULT: regRdData = result_reg;
            `BCDALU_OFF_SEL: regRdData = {4'h0, selected_register_reg};
            default: begin
               if (rdAddr_reg >= `BCDALU_OFF_FILE
                  && rdAddr_reg < (`BCDALU_OFF_FILE + `BCDALU_FILE_DEPTH)) begin
                  regRdData = fileRd;
               end
            end
         endcase
      end
   end
endmodule // bcdalu_core

// >>> src/bcdalu_regfile.v
// Small register file holding the working registers the datapath operates on.
// Assumes one write port and one registered read port on ref_clk.
`timescale 1ns/100ps
module bcdalu_regfile #(
   parameter DW = 8,
   parameter AW = 4,
   parameter DEPTH = 16
) (
   input wire ref_clk,
   input wire wrEn,
   input wire [AW-1:0] wrAddr,
   input wire [DW-1:0] wrData,
   input wire [AW-1:0] rdAddr,
   output reg [DW-1:0] rdData
);
   reg [DW-1:0] mem [0:DEPTH-1];
   always @(posedge ref_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule // bcdalu_regfile

// >>> testbench/bcdalu_chk.sv
// Port checker for the decimal-add and decrement slice.
// Assumes it is bound to bcdalu_core and sees only its ports.
`timescale 1ns/100ps
module bcdalu_chk (
   input wire ref_clk,
   input wire rst_b,
   input wire [7:0] regAddr,
   input wire regRdStb,
   input wire [7:0] regRdData
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // A stale read value left on the bus would be mistaken for a fresh answer.
   a_idle_read_zero: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
      else $error("read data not zero outside a read answer");
   a_hole_read_zero: assert property (regRdStb && regAddr == 8'h05 |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   a_status_nibble: assert property (
      regRdStb && regAddr == 8'h02 |=> regRdData[7:4] == 4'h0)
      else $error("status read has bits above the four flags");
   a_ctrl_upper_zero: assert property (
      regRdStb && regAddr == 8'h00 |=> regRdData[7:2] == 6'h00)
      else $error("control read has bits above the operation code");
   a_sel_nibble: assert property (
      regRdStb && regAddr == 8'h04 |=> regRdData[7:4] == 4'h0)
      else $error("register select read wider than its index");
   a_reset_read_zero: assert property (@(posedge ref_clk) disable iff (1'b0)
      !rst_b |-> regRdData == 8'h00)
      else $error("read data not zero while in reset");
endmodule // bcdalu_chk

// >>> testbench/bcdalu_host.sv
// Register-port master standing for the core that drives the slice.
// Assumes the one-cycle strobe protocol of the register port.
`timescale 1ns/100ps
module bcdalu_host (
   input wire ref_clk,
   input wire [7:0] regRdData,
   output reg [7:0] regAddr,
   output reg [7:0] regWrData,
   output reg regWrStb,
   output reg regRdStb
);
   initial {regAddr, regWrData, regWrStb, regRdStb} = 18'h0;
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge ref_clk);
      {regAddr, regWrData, regWrStb} <= {a, d, 1'b1};
      @(posedge ref_clk);
      regWrStb <= 1'b0;
   end
   endtask
   task rd(input [7:0] a, output [7:0] d);
   begin
      @(posedge ref_clk);
      {regAddr, regRdStb} <= {a, 1'b1};
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      // Read data stand only in the cycle after the strobe, so take them at its closing edge.
      @(posedge ref_clk);
      d = regRdData;
   end
   endtask
endmodule // bcdalu_host

// >>> testbench/tb.sv
// Self-checking bench for the decimal-add and decrement slice.
// Assumes bcdalu_core, bcdalu_host and bcdalu_chk are compiled first.
`timescale 1ns/100ps
module tb;
   reg ref_clk = 1'b0;
   reg rst_b = 1'b0;
   wire [7:0] regAddr, regWrData, regRdData;
   wire regWrStb, regRdStb;
   integer num_errors = 0;
   integer tests_run = 0;
   always #20 ref_clk = ~ref_clk;
   bcdalu_core uut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData));
   bcdalu_host host (.ref_clk(ref_clk), .regRdData(regRdData), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb));
   task chk(input [8*6-1:0] nm, input [7:0] e, input [7:0] g);
   begin
      tests_run = tests_run + 1;
      if (g !== e) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   // Status is written before each go, so every case starts from known flags.
   task run(input [3:0] s, input [7:0] v, input [7:0] src, input [7:0] st,
      input [7:0] go, input [7:0] er, input [7:0] ef);
      reg [7:0] d;
   begin
      host.wr(8'h04, {4'h0, s});
      host.wr(8'h10 + s, v);
      host.wr(8'h01, src);
      host.wr(8'h02, st);
      host.wr(8'h00, go);
      repeat (3) @(posedge ref_clk);
      host.rd(8'h10 + s, d);
      chk("result", er, d);
      host.rd(8'h03, d);
      chk("last", er, d);
      host.rd(8'h02, d);
      chk("flags", ef, d);
   end
   endtask
   task t_dac;
   begin
      run(4'h4, 8'h97, 8'h24, 8'h00, 8'h01, 8'h21, 8'h01);
      run(4'h5, 8'h45, 8'h54, 8'h00, 8'h01, 8'h99, 8'h02);
      run(4'h3, 8'h50, 8'h50, 8'h00, 8'h01, 8'h00, 8'h05);
      $display("decimal add done");
   end
   endtask
   task t_chain;
   begin
      run(4'h6, 8'h99, 8'h00, 8'h01, 8'h01, 8'h00, 8'h05);
      run(4'h7, 8'h12, 8'h00, 8'h00, 8'h01, 8'h12, 8'h00);
      $display("carry chain done");
   end
   endtask
   task t_dec;
   begin
      run(4'h0, 8'h00, 8'h00, 8'h00, 8'h02, 8'hFF, 8'h02);
      run(4'h1, 8'h80, 8'h00, 8'h00, 8'h02, 8'h7F, 8'h09);
      run(4'hF, 8'h01, 8'h00, 8'h0F, 8'h02, 8'h00, 8'h05);
      $display("decrement done");
   end
   endtask
   task t_hole;
      reg [7:0] d;
   begin
      host.rd(8'h05, d);
      chk("hole", 8'h00, d);
      $display("unmapped read done");
   end
   endtask
   task t_regs;
      reg [7:0] d;
   begin
      host.wr(8'h04, 8'h09);
      host.rd(8'h04, d);
      chk("select", 8'h09, d);
      host.rd(8'h00, d);
      chk("ctrl", 8'h00, d);
      $display("register readback done");
   end
   endtask
   task finish_test;
   begin
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_dac;
      t_chain;
      t_dec;
      t_hole;
      t_regs;
      finish_test;
   end
   initial begin
      #400000;
      num_errors = num_errors + 1;
      finish_test;
   end
endmodule // tb
bind bcdalu_core bcdalu_chk chk (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
   .regRdStb(regRdStb), .regRdData(regRdData));
